/* core/seq0_sample_input_select.sv */
// sequence-0 input select: APB register file plus per-step mux select driver
// assumes the sequencer outside presents step_valid/step_idx for one cycle per step
// Operation
// R1: step 7 (seventh) uses read/write bits 25:24, reset zero, as input select.
// R2: step 6 (sixth) uses read/write bits 21:20, reset zero, as input select.
// R3: step 5 (fifth) uses read/write bits 17:16, reset zero, as input select.
// R4: step 4 (fourth) uses read/write bits 13:12, reset zero, as input select.
// R5: step 3 (third) uses read/write bits 9:8, reset zero, as input select.
// R6: step 2 (second) uses read/write bits 5:4, reset zero, as input select.
// R7: step 1 (first) uses read/write bits 1:0, reset zero, as input select.
// R8: software ignores reserved bits and writes back what it read.
// R9: step 8 (eighth) uses read/write bits 29:28, reset zero, as input select.
// R10: no conversion requested for steps after the end-marked step.
// R11: while step n executes, mux select shows step n's current field.
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "seq0_params.svh"

module seq0_sample_input_select (
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // apb slave
  input  wire logic [`SEQ0_ADDR_W-1:0] paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // sequencer step
  input  wire logic                    step_valid,
  input  wire logic [2:0]              step_idx,
  // analog front end
  output logic      [`SEQ0_SEL_W-1:0]  mux_sel,
  output logic                         conv_req,
  output logic                         step_last
);

  seq0_step_if lk ();

  seq0_pkg::apb_st_t          st_r;
  seq0_pkg::apb_st_t          st_nxt;
  logic [31:0]                sel_word_r;
  logic [31:0]                end_word_r;
  logic [31:0]                prdata_r;
  logic [31:0]                prdata_nxt;
  logic                       pslverr_r;
  logic                       pslverr_nxt;
  logic                       pready_r;
  seq0_pkg::insel_t           mux_sel_r;
  logic                       conv_req_r;
  logic                       step_last_r;
  seq0_pkg::step_t            last_idx_r;
  logic [`SEQ0_SUPP_W-1:0]    supp_cnt_r;
  logic [`SEQ0_SUPP_W-1:0]    supp_cnt_nxt;

  // decode
  wire        setup_ph   = psel & ~penable;
  wire        access_ph  = psel & penable & (st_r == seq0_pkg::ST_ACC);
  wire        hit_insel  = (paddr == `SEQ0_INSEL_OFS);
  wire        hit_end    = (paddr == `SEQ0_END_OFS);
  wire        hit_stat   = (paddr == `SEQ0_STAT_OFS);
  wire        mapped     = hit_insel | hit_end | hit_stat;
  wire        wr_insel   = access_ph & pwrite & hit_insel & ~pslverr_r;
  wire        wr_end     = access_ph & pwrite & hit_end & ~pslverr_r;
  wire        supp_step  = step_valid & ~lk.allowed;
  wire        req_step   = step_valid & lk.allowed;
  wire        supp_full  = &supp_cnt_r;

  // reserved pairs are read-only zero: masked on write, never stored
  wire [31:0] insel_wr_val = pwdata & `SEQ0_INSEL_WMASK;
  wire [31:0] end_wr_val   = pwdata & `SEQ0_END_WMASK;

  wire [31:0] stat_word = {8'h00, supp_cnt_r, 8'h00, step_last_r, last_idx_r,
                           conv_req_r, 1'b0, mux_sel_r};

  // the status register is read-only; a write to it is accepted and dropped
  assign prdata_nxt  = hit_insel ? sel_word_r :
                       hit_end   ? end_word_r :
                       hit_stat  ? stat_word  : 32'h0000_0000;
  assign pslverr_nxt = ~mapped;
  assign st_nxt      = setup_ph ? seq0_pkg::ST_ACC : seq0_pkg::ST_IDLE;
  assign supp_cnt_nxt = (supp_step & ~supp_full) ? supp_cnt_r + 8'h01 : supp_cnt_r;

  assign lk.sel_word = sel_word_r;
  assign lk.end_word = end_word_r;
  assign lk.step_idx = step_idx;

  seq0_step_lookup u_lookup (
    .lk (lk.lookup)
  );

  // apb handshake: one wait-free access phase after each setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= seq0_pkg::ST_IDLE;
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      pready_r  <= setup_ph;
      prdata_r  <= setup_ph ? prdata_nxt : 32'h0000_0000;
      pslverr_r <= setup_ph & pslverr_nxt;
    end
  end

  // select fields: all eight steps live in one word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_word_r <= `SEQ0_INSEL_RST;                  // [R1] [R2] [R3] [R4] [R5] [R6] [R7] [R9]
    end else if (wr_insel) begin
      sel_word_r <= insel_wr_val;                     // [R1] [R2] [R3] [R4] [R5] [R6] [R7] [R9]
    end
  end

  // end-of-sequence marks, one per step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      end_word_r <= `SEQ0_END_RST;
    end else if (wr_end) begin
      end_word_r <= end_wr_val;
    end
  end

  // step outputs; the field is sampled at the step's own edge, so a write
  // landing in the same cycle affects the next step, not this one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_sel_r   <= 2'h0;
      conv_req_r  <= 1'b0;
      step_last_r <= 1'b0;
      last_idx_r  <= 3'h0;
    end else begin
      if (step_valid) begin
        mux_sel_r  <= lk.sel;                         // [R11]
        last_idx_r <= step_idx;
      end
      conv_req_r  <= req_step;                        // [R10]
      step_last_r <= req_step & lk.is_last;
    end
  end

  // saturating count of suppressed steps, for software diagnosis
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supp_cnt_r <= 8'h00;
    end else begin
      supp_cnt_r <= supp_cnt_nxt;
    end
  end

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign mux_sel   = mux_sel_r;
  assign conv_req  = conv_req_r;
  assign step_last = step_last_r;

  // checks on each step's select field
  property p_sel_step0;
    @(posedge pclk) disable iff (!presetn)
      step_valid && step_idx == 3'h0 |=> mux_sel == $past(sel_word_r[1:0]);
  endproperty
  a_sel_step0: assert property (p_sel_step0) else $error("step 0 select wrong"); // [R7]

  property p_sel_step1;
    @(posedge pclk) disable iff (!presetn)
      step_valid && step_idx == 3'h1 |=> mux_sel == $past(sel_word_r[5:4]);
  endproperty
  a_sel_step1: assert property (p_sel_step1) else $error("step 1 select wrong"); // [R6]

  property p_sel_step2;
    @(posedge pclk) disable iff (!presetn)
      step_valid && step_idx == 3'h2 |=> mux_sel == $past(sel_word_r[9:8]);
  endproperty
  a_sel_step2: assert property (p_sel_step2) else $error("step 2 select wrong"); // [R5]

  property p_sel_step3;
    @(posedge pclk) disable iff (!presetn)
      step_valid && step_idx == 3'h3 |=> mux_sel == $past(sel_word_r[13:12]);
  endproperty
  a_sel_step3: assert property (p_sel_step3) else $error("step 3 select wrong"); // [R4]

  property p_sel_step4;
    @(posedge pclk) disable iff (!presetn)
      step_valid && step_idx == 3'h4 |=> mux_sel == $past(sel_word_r[17:16]);
  endproperty
  a_sel_step4: assert property (p_sel_step4) else $error("step 4 select wrong"); // [R3]

  property p_sel_step5;
    @(posedge pclk) disable iff (!presetn)
      step_valid && step_idx == 3'h5 |=> mux_sel == $past(sel_word_r[21:20]);
  endproperty
  a_sel_step5: assert property (p_sel_step5) else $error("step 5 select wrong"); // [R2]

  property p_sel_step6;
    @(posedge pclk) disable iff (!presetn)
      step_valid && step_idx == 3'h6 |=> mux_sel == $past(sel_word_r[25:24]);
  endproperty
  a_sel_step6: assert property (p_sel_step6) else $error("step 6 select wrong"); // [R1]

  property p_sel_step7;
    @(posedge pclk) disable iff (!presetn)
      step_valid && step_idx == 3'h7 |=> mux_sel == $past(sel_word_r[29:28]);
  endproperty
  a_sel_step7: assert property (p_sel_step7) else $error("step 7 select wrong"); // [R9]

  property p_write_lands;
    @(posedge pclk) disable iff (!presetn)
      psel && penable && pready && pwrite && paddr == `SEQ0_INSEL_OFS
      |=> sel_word_r == ($past(pwdata) & `SEQ0_INSEL_WMASK);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("select write lost"); // [R1]

  property p_no_req_after_end;
    @(posedge pclk) disable iff (!presetn)
      step_valid && step_idx == 3'h3 && end_word_r[1] |=> !conv_req;
  endproperty
  a_no_req_after_end: assert property (p_no_req_after_end) else $error("req after end"); // [R10]

  property p_req_follows_step;
    @(posedge pclk) disable iff (!presetn)
      conv_req |-> $past(step_valid);
  endproperty
  a_req_follows_step: assert property (p_req_follows_step) else $error("stray request"); // [R10]

  property p_hold_between_steps;
    @(posedge pclk) disable iff (!presetn)
      !step_valid |=> $stable(mux_sel);
  endproperty
  a_hold_between_steps: assert property (p_hold_between_steps) else $error("sel moved"); // [R11]

  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn)
      (sel_word_r & ~`SEQ0_INSEL_WMASK) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_ready_one_cycle;
    @(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready ##1 !pready;
  endproperty
  a_ready_one_cycle: assert property (p_ready_one_cycle) else $error("pready timing wrong");

  // bus and end-mark checks, written against the raw words, not the lookup
  property p_req_step0;
    @(posedge pclk) disable iff (!presetn)
      step_valid && step_idx == 3'h0 |=> conv_req;
  endproperty
  a_req_step0: assert property (p_req_step0) else $error("step 0 not requested"); // [R10]

  property p_cut_after_step0;
    @(posedge pclk) disable iff (!presetn)
      step_valid && step_idx != 3'h0 && end_word_r[1] |=> !conv_req && !step_last;
  endproperty
  a_cut_after_step0: assert property (p_cut_after_step0) else $error("late request"); // [R10]

  property p_last_step0;
    @(posedge pclk) disable iff (!presetn)
      step_valid && step_idx == 3'h0 && end_word_r[1] |=> step_last;
  endproperty
  a_last_step0: assert property (p_last_step0) else $error("end mark lost"); // [R10]

  property p_last_needs_req;
    @(posedge pclk) disable iff (!presetn)
      step_last |-> conv_req;
  endproperty
  a_last_needs_req: assert property (p_last_needs_req) else $error("bare last"); // [R10]

  property p_count_cut;
    @(posedge pclk) disable iff (!presetn)
      step_valid && step_idx != 3'h0 && end_word_r[1] && supp_cnt_r != 8'hFF
      |=> supp_cnt_r == $past(supp_cnt_r) + 8'h01;
  endproperty
  a_count_cut: assert property (p_count_cut) else $error("cut step not counted"); // [R10]

  property p_unmapped_err;
    @(posedge pclk) disable iff (!presetn)
      psel && !penable && paddr != `SEQ0_INSEL_OFS && paddr != `SEQ0_END_OFS
      && paddr != `SEQ0_STAT_OFS |=> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("no error on bad address");

  property p_idle_bus_quiet;
    @(posedge pclk) disable iff (!presetn)
      !pready |-> prdata == 32'h0000_0000 && !pslverr;
  endproperty
  a_idle_bus_quiet: assert property (p_idle_bus_quiet) else $error("bus output outside access");

  property p_read_sel;
    @(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == `SEQ0_INSEL_OFS
      |=> prdata == $past(sel_word_r);
  endproperty
  a_read_sel: assert property (p_read_sel) else $error("select read wrong"); // [R1]

  property p_end_write_lands;
    @(posedge pclk) disable iff (!presetn)
      psel && penable && pready && pwrite && paddr == `SEQ0_END_OFS
      |=> end_word_r == ($past(pwdata) & `SEQ0_END_WMASK);
  endproperty
  a_end_write_lands: assert property (p_end_write_lands) else $error("end write lost"); // [R10]

  property p_stat_read_only;
    @(posedge pclk) disable iff (!presetn)
      psel && penable && pready && pwrite && paddr == `SEQ0_STAT_OFS
      |=> $stable(sel_word_r) && $stable(end_word_r);
  endproperty
  a_stat_read_only: assert property (p_stat_read_only) else $error("status write landed");

  c_write_then_step: cover property (@(posedge pclk) disable iff (!presetn)
    wr_insel ##[1:20] (step_valid && step_idx == 3'h7));
  c_suppressed: cover property (@(posedge pclk) disable iff (!presetn)
    step_valid && !lk.allowed);
  c_last_step: cover property (@(posedge pclk) disable iff (!presetn) step_last);
  c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);

endmodule : seq0_sample_input_select

`default_nettype wire

/* core/seq0_params.svh */
// constants for the sequence-0 input-select block: offsets, masks, resets, sizes
// assumes byte addresses on a 32-bit APB, one aligned word per register
`ifndef SEQ0_PARAMS_SVH
`define SEQ0_PARAMS_SVH

`define SEQ0_ADDR_W        12
`define SEQ0_INSEL_OFS     12'h040
`define SEQ0_END_OFS       12'h044
`define SEQ0_STAT_OFS      12'h048
`define SEQ0_INSEL_WMASK   32'h3333_3333
`define SEQ0_END_WMASK     32'h2222_2222
`define SEQ0_INSEL_RST     32'h0000_0000
`define SEQ0_END_RST       32'h0000_0000
`define SEQ0_STEPS         8
`define SEQ0_SEL_W         2
`define SEQ0_FIELD_STRIDE  4
`define SEQ0_END_BIT       1
`define SEQ0_SUPP_W        8

`endif

/* core/seq0_pkg.sv */
// types shared by the sequence-0 input-select block
// assumes seq0_params.svh sets widths and step count
`include "seq0_params.svh"

package seq0_pkg;
  typedef logic [`SEQ0_SEL_W-1:0] insel_t;
  typedef logic [2:0]             step_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACC  = 2'b10
  } apb_st_t;
endpackage : seq0_pkg

/* core/seq0_step_if.sv */
// step lookup carrier between the register file and the field selector
// assumes a single clock domain; purely combinational signals
`timescale 1ns/1ns
`default_nettype none

interface seq0_step_if;
  logic [31:0]          sel_word;
  logic [31:0]          end_word;
  seq0_pkg::step_t      step_idx;
  seq0_pkg::insel_t     sel;
  logic                 allowed;
  logic                 is_last;

  modport owner  (output sel_word, output end_word, output step_idx,
                  input sel, input allowed, input is_last);
  modport lookup (input sel_word, input end_word, input step_idx,
                  output sel, output allowed, output is_last);
endinterface : seq0_step_if

`default_nettype wire

/* core/seq0_step_lookup.sv */
// picks the current step's select field and end-of-sequence status
// assumes the owner holds the register words stable for the lookup
`timescale 1ns/1ns
`default_nettype none
`include "seq0_params.svh"

module seq0_step_lookup (
  // step lookup
  seq0_step_if.lookup lk
);

  function automatic seq0_pkg::insel_t field_at(input logic [31:0] w,
                                                 input seq0_pkg::step_t idx);
    field_at = w[idx*`SEQ0_FIELD_STRIDE +: `SEQ0_SEL_W];
  endfunction : field_at

  function automatic logic end_at(input logic [31:0] w, input seq0_pkg::step_t idx);
    end_at = w[idx*`SEQ0_FIELD_STRIDE + `SEQ0_END_BIT];
  endfunction : end_at

  // true if some earlier step carries the end mark
  function automatic logic end_before(input logic [31:0] w, input seq0_pkg::step_t idx);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < `SEQ0_STEPS; i++) begin
      if (i < int'(idx) && end_at(w, 3'(i))) begin
        hit = 1'b1;
      end
    end
    end_before = hit;
  endfunction : end_before

  assign lk.sel     = field_at(lk.sel_word, lk.step_idx);
  assign lk.allowed = ~end_before(lk.end_word, lk.step_idx);  // [R10]
  assign lk.is_last = end_at(lk.end_word, lk.step_idx);

endmodule : seq0_step_lookup

`default_nettype wire

/* dv/afe_model.sv */
// behavioural analog front end: converts the selected input on each request
// assumes conv_req is a one-cycle pulse with mux_sel settled beside it
`timescale 1ns/1ns
`default_nettype none
`include "seq0_params.svh"

module afe_model (
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // from the input select block
  input  wire logic [`SEQ0_SEL_W-1:0] mux_sel,
  input  wire logic                   conv_req,
  // converted sample report
  output logic                        conv_seen,
  output logic      [`SEQ0_SEL_W-1:0] conv_ch
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_seen <= 1'b0;
      conv_ch   <= '0;
    end else begin
      conv_seen <= conv_req;
      // channel flips outside a conversion so a stale value never looks valid
      conv_ch   <= conv_req ? mux_sel : ~conv_ch;
    end
  end
endmodule : afe_model

`default_nettype wire

/* dv/tb_seq0_sample_input_select.sv */
// testbench: apb register checks and step sequencing against a shadow copy
// assumes seq0_params.svh on the include path and afe_model alongside
`timescale 1ns/1ns
`default_nettype none
`include "seq0_params.svh"
`define CHK(nm, ex, gt) \
  compares++; \
  if ((gt) !== (ex)) begin \
    errors++; \
    $display("[ERR] %s expected %0h seen %0h", nm, ex, gt); \
  end

module tb_seq0_sample_input_select;
  logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [`SEQ0_ADDR_W-1:0] paddr;
  logic [31:0]             pwdata, prdata, rng, sel_w, end_w, rd;
  logic                    step_valid, conv_req, step_last, conv_seen, pend;
  logic [2:0]              step_idx;
  logic [1:0]              mux_sel, conv_ch;
  logic [32:0]             rd_q[$];
  logic [3:0]              st_q[$];
  logic [1:0]              cv_q[$];
  int                      errors, compares, cycles;
  int                      end_pos [3] = '{0, 3, 7};

  seq0_sample_input_select i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .step_valid(step_valid), .step_idx(step_idx),
    .mux_sel(mux_sel), .conv_req(conv_req), .step_last(step_last));
  afe_model i_afe (.pclk(pclk), .presetn(presetn), .mux_sel(mux_sel),
    .conv_req(conv_req), .conv_seen(conv_seen), .conv_ch(conv_ch));

  always #10 pclk = ~pclk;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic report_and_stop();
    if (errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // ex is {pslverr, prdata}, noted only for reads
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [32:0] ex);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    if (!w) rd_q.push_back(ex);
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr_sel(input logic [31:0] d);
    sel_w = d & `SEQ0_INSEL_WMASK;
    apb(`SEQ0_INSEL_OFS, 1'b1, d, '0);
  endtask : wr_sel

  // notes the step result and, if not past an end mark, the conversion
  task automatic step(input int n);
    logic cut;
    logic [1:0] s;
    cut = 1'b0;
    for (int k = 0; k < n; k++) cut |= end_w[4*k+1];
    s = sel_w[4*n +: 2];
    @(posedge pclk);
    step_valid <= 1'b1;
    step_idx   <= n[2:0];
    st_q.push_back({~cut, end_w[4*n+1] & ~cut, s});
    if (!cut) cv_q.push_back(s);
  endtask : step

  task automatic idle();
    @(posedge pclk);
    step_valid <= 1'b0;
  endtask : idle

  always @(posedge pclk) begin
    logic [32:0] r;
    logic [3:0]  t;
    logic [1:0]  c;
    cycles++;
    if (cycles > 20000) begin
      errors++;
      report_and_stop();
    end
    if (pend) begin
      t = st_q.pop_front();
      `CHK("step", t, {conv_req, step_last, mux_sel})
    end
    pend <= step_valid;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      r  = rd_q.pop_front();
      rd = prdata;
      `CHK("read", r, {pslverr, prdata})
    end
    if (conv_seen === 1'b1) begin
      c = cv_q.pop_front();
      `CHK("conv", c, conv_ch)
    end
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite, step_valid, pend} = '0;
    {paddr, pwdata, step_idx, sel_w, end_w, rd} = '0;
    {errors, compares, cycles} = '0;
    rng = 32'h0000_AEC2;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(`SEQ0_INSEL_OFS, 1'b0, '0, {1'b0, `SEQ0_INSEL_RST});
    apb(`SEQ0_END_OFS, 1'b0, '0, {1'b0, `SEQ0_END_RST});
    apb(12'h04C, 1'b1, 32'hFFFF_FFFF, '0);
    apb(12'h04C, 1'b0, '0, 33'h1_0000_0000);
    wr_sel(32'hFFFF_FFFF);
    apb(`SEQ0_STAT_OFS, 1'b1, 32'h0000_0000, '0);
    apb(`SEQ0_INSEL_OFS, 1'b0, '0, {1'b0, 32'h3333_3333});
    // every select code in every field, steps back to back
    for (int v = 0; v < 4; v++) begin
      wr_sel(v * 32'h1111_1111);
      for (int n = 0; n < 8; n++) step(n);
      idle();
    end
    // random contents, random step order
    repeat (8) begin
      rng = xs(rng);
      wr_sel(rng);
      for (int n = 0; n < 8; n++) step(int'(rng[3*n +: 3]));
      idle();
    end
    // end mark on first, middle and last step; later steps suppressed
    foreach (end_pos[i]) begin
      end_w = 32'h1 << (4 * end_pos[i] + 1);
      apb(`SEQ0_END_OFS, 1'b1, end_w, '0);
      rng = xs(rng);
      wr_sel(rng);
      for (int n = 7; n >= 0; n--) step(n);
      for (int n = 0; n < 8; n++) step(n);
      idle();
    end
    // status: 7+7 cut steps at mark 0, 4+4 at mark 3; step 7 last, select held
    apb(`SEQ0_STAT_OFS, 1'b0, '0,
        {1'b0, 8'h00, 8'h16, 8'h00, 1'b0, 3'h7, 2'h0, sel_w[29:28]});
    // read-modify-write of step 3 keeps the other fields
    apb(`SEQ0_INSEL_OFS, 1'b0, '0, {1'b0, sel_w});
    @(posedge pclk);
    wr_sel((rd & ~32'h0000_3000) | 32'h0000_2000);
    apb(`SEQ0_INSEL_OFS, 1'b0, '0, {1'b0, sel_w});
    repeat (4) @(posedge pclk);
    `CHK("queues", 0, st_q.size() + cv_q.size() + rd_q.size())
    report_and_stop();
  end
endmodule : tb_seq0_sample_input_select

`default_nettype wire
